// ==== hw/ioa_params.svh ====
// Constants for the increment, OR and shift execution datapath.
// Assumes inclusion by bare name from the design files under hw/.
`ifndef IOA_PARAMS_SVH
`define IOA_PARAMS_SVH
`define IOA_DATA_W 8
`define IOA_ADDR_W 7
`define IOA_FILE_DEPTH 128
`define IOA_ACC_RESET 8'h00
`define IOA_FILE_RESET 8'h00
`define IOA_ONE 8'h01
`define IOA_ZERO 8'h00
`define IOA_MSB 7
`define IOA_LSB 0
`endif

// ==== hw/ioa_pkg.sv ====
// Types for the increment, OR and shift execution datapath.
// Assumes nothing beyond a SystemVerilog compiler.
package ioa_pkg;
   // Operation codes presented to the datapath by the decoder.
   typedef enum logic [2:0] {
      IOA_OP_NONE = 3'h0,
      IOA_OP_ADD_ONE = 3'h1,
      IOA_OP_ADD_ONE_SKIP = 3'h2,
      IOA_OP_OR_LITERAL = 3'h3,
      IOA_OP_OR_FILE = 3'h4,
      IOA_OP_SHIFT_LEFT = 3'h5,
      IOA_OP_SHIFT_RIGHT = 3'h6
   } ioa_op_t;
   // Execution sequencer states.
   typedef enum logic {
      IOA_ST_RUN,
      IOA_ST_IDLE_SLOT
   } ioa_state_t;
endpackage : ioa_pkg

// ==== hw/ioa_file_mem.sv ====
// Small register file memory with a registered read port.
// Assumes a single clock; write and read may hit the same address in one cycle.
`timescale 1ns/100ps
`include "ioa_params.svh"
module ioa_file_mem #(
   parameter int DATA_W = `IOA_DATA_W,
   parameter int ADDR_W = `IOA_ADDR_W,
   parameter int DEPTH = `IOA_FILE_DEPTH
) (
   // Clock and reset.
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   // Write port.
   input wire logic wr_en_in,
   input wire logic [ADDR_W-1:0] wr_addr_in,
   input wire logic [DATA_W-1:0] wr_data_in,
   // Read port, data one cycle after the address.
   input wire logic [ADDR_W-1:0] rd_addr_in,
   output logic [DATA_W-1:0] rd_data_out
);
   logic [DATA_W-1:0] mem_q [DEPTH];
   logic [DATA_W-1:0] rd_data_q;

   // Storage array, cleared at reset so every read is defined.
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= DATA_W'(`IOA_FILE_RESET);
         end
      end else if (wr_en_in) begin
         mem_q[wr_addr_in] <= wr_data_in;
      end
   end

   // Registered read; a same-cycle write returns the old contents.
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rd_data_q <= DATA_W'(`IOA_FILE_RESET);
      end else begin
         rd_data_q <= mem_q[rd_addr_in];
      end
   end

   assign rd_data_out = rd_data_q;
endmodule : ioa_file_mem

// ==== hw/ioa_alu.sv ====
// Execution datapath for increment, increment-skip, OR and logical shifts.
// Assumes a decoder that presents one instruction at a time with a start pulse
// and waits for done before the next one.
//
// Notes on behaviour
// - Seven-bit address; select clear writes accumulator.
// - Select set writes back to file register.
// - Add one: increment file, update nil flag.
// - Add-one-skip zero: idle slot, flags untouched.
// - Add-one-skip nonzero: next instruction runs normally.
// - OR literal into accumulator, update nil flag.
// - OR file with accumulator to destination, nil.
// - Shift left: bits up, zero into bit 0.
// - Shift left: old bit 7 to shift-out, nil.
// - Shift right: bits down, zero into bit 7.
// - Shift right: old bit 0 to shift-out, nil.
`timescale 1ns/100ps
`include "ioa_params.svh"
module ioa_alu #(
   parameter int DATA_W = `IOA_DATA_W,
   parameter int ADDR_W = `IOA_ADDR_W
) (
   // Clock and reset.
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   // Instruction from the decoder.
   input wire logic start_in,
   input wire ioa_pkg::ioa_op_t op_in,
   input wire logic [ADDR_W-1:0] file_addr_in,
   input wire logic dest_sel_in,
   input wire logic [DATA_W-1:0] literal_in,
   // Sequencing answers.
   output logic busy_out,
   output logic done_out,
   output logic idle_slot_out,
   // Architectural state.
   output logic [DATA_W-1:0] acc_out,
   output logic result_nil_flag_out,
   output logic shift_out_flag_out
);
   ioa_pkg::ioa_op_t op_q;
   logic [ADDR_W-1:0] addr_q;
   logic dest_q;
   logic [DATA_W-1:0] lit_q;
   logic exec_q;
   ioa_pkg::ioa_state_t state_q;
   ioa_pkg::ioa_state_t state_d;
   logic [DATA_W-1:0] acc_q;
   logic nil_q;
   logic shout_q;
   logic done_q;
   logic idle_q;
   logic [DATA_W-1:0] file_rd;

   // Increment forms share the one adder.
   function automatic logic is_incr_op(input ioa_pkg::ioa_op_t op);
      return (op == ioa_pkg::IOA_OP_ADD_ONE) || (op == ioa_pkg::IOA_OP_ADD_ONE_SKIP);
   endfunction : is_incr_op

   // Shift forms load the shift-out flag.
   function automatic logic is_shift_op(input ioa_pkg::ioa_op_t op);
      return (op == ioa_pkg::IOA_OP_SHIFT_LEFT) || (op == ioa_pkg::IOA_OP_SHIFT_RIGHT);
   endfunction : is_shift_op

   // The literal form has no file operand, so it never writes back.
   function automatic logic is_file_op(input ioa_pkg::ioa_op_t op);
      return (op != ioa_pkg::IOA_OP_NONE) && (op != ioa_pkg::IOA_OP_OR_LITERAL);
   endfunction : is_file_op

   // Capture the instruction while the datapath is free.
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         op_q <= ioa_pkg::IOA_OP_NONE;
         addr_q <= '0;
         dest_q <= 1'b0;
         lit_q <= '0;
         exec_q <= 1'b0;
      end else begin
         exec_q <= start_in && !busy_out;
         if (start_in && !busy_out) begin
            op_q <= op_in;
            addr_q <= file_addr_in;
            dest_q <= dest_sel_in;
            lit_q <= literal_in;
         end
      end
   end

   // Result selection.
   logic [DATA_W-1:0] sum_one;
   logic [DATA_W-1:0] or_lit;
   logic [DATA_W-1:0] or_file;
   logic [DATA_W-1:0] shl;
   logic [DATA_W-1:0] shr;
   logic [DATA_W-1:0] result;
   logic result_nil;
   assign sum_one = DATA_W'(file_rd + DATA_W'(`IOA_ONE));
   assign or_lit = acc_q | lit_q;
   assign or_file = acc_q | file_rd;
   assign shl = {file_rd[DATA_W-2:0], 1'b0};
   assign shr = {1'b0, file_rd[DATA_W-1:1]};
   assign result = is_incr_op(op_q) ? sum_one :
                   (op_q == ioa_pkg::IOA_OP_OR_LITERAL) ? or_lit :
                   (op_q == ioa_pkg::IOA_OP_OR_FILE) ? or_file :
                   (op_q == ioa_pkg::IOA_OP_SHIFT_LEFT) ? shl :
                   (op_q == ioa_pkg::IOA_OP_SHIFT_RIGHT) ? shr : acc_q;
   assign result_nil = (result == DATA_W'(`IOA_ZERO));

   // Destination decode.
   logic op_valid;
   logic to_file;
   logic to_acc;
   logic file_wr;
   logic nil_upd;
   logic sh_upd;
   logic skip_now;
   // A NONE op is taken and answered but changes nothing.
   assign op_valid = exec_q && (op_q != ioa_pkg::IOA_OP_NONE);
   assign to_file = op_valid && dest_q && is_file_op(op_q);
   assign to_acc = op_valid && !to_file;
   // The file is written only for file forms with the select set.
   assign file_wr = to_file;
   assign nil_upd = op_valid && (op_q != ioa_pkg::IOA_OP_ADD_ONE_SKIP);
   assign sh_upd = op_valid && is_shift_op(op_q);
   assign skip_now = op_valid && (op_q == ioa_pkg::IOA_OP_ADD_ONE_SKIP) && result_nil;

   // File operand read; data arrives the cycle after the start pulse.
   // The write lands at the end of the execute cycle while busy holds off the next
   // start, so the operand read of the next instruction always sees the new value.
   ioa_file_mem #(
      .DATA_W(DATA_W),
      .ADDR_W(ADDR_W),
      .DEPTH(1 << ADDR_W)
   ) u_file (
      .ref_clk_in(ref_clk_in),
      .reset_n_in(reset_n_in),
      .wr_en_in(file_wr),
      .wr_addr_in(addr_q),
      .wr_data_in(result),
      .rd_addr_in(file_addr_in),
      .rd_data_out(file_rd)
   );

   // Bit pushed out by the shift: bit 7 going left, bit 0 going right.
   logic shout_d;
   assign shout_d = (op_q == ioa_pkg::IOA_OP_SHIFT_LEFT) ? file_rd[`IOA_MSB] : file_rd[`IOA_LSB];

   // Accumulator and flags.
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         acc_q <= DATA_W'(`IOA_ACC_RESET);
         nil_q <= 1'b0;
         shout_q <= 1'b0;
      end else begin
         if (to_acc) begin
            acc_q <= result;
         end
         if (nil_upd) begin
            nil_q <= result_nil;
         end
         // Shift-out flag loads only on a shift.
         if (sh_upd) begin
            shout_q <= shout_d;
         end
      end
   end

   // Sequencer: a zero skip spends one extra cycle as an idle slot.
   always_comb begin
      state_d = state_q;
      case (state_q)
         ioa_pkg::IOA_ST_RUN: begin
            if (skip_now) begin
               state_d = ioa_pkg::IOA_ST_IDLE_SLOT;
            end
         end
         ioa_pkg::IOA_ST_IDLE_SLOT: begin
            state_d = ioa_pkg::IOA_ST_RUN;
         end
         default: begin
            state_d = ioa_pkg::IOA_ST_RUN;
         end
      endcase
   end

   // State and answer registers.
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_q <= ioa_pkg::IOA_ST_RUN;
         done_q <= 1'b0;
         idle_q <= 1'b0;
      end else begin
         state_q <= state_d;
         done_q <= (exec_q && !skip_now) || (state_q == ioa_pkg::IOA_ST_IDLE_SLOT);
         idle_q <= (state_q == ioa_pkg::IOA_ST_IDLE_SLOT);
      end
   end

   // Busy spans the execute cycle and any idle slot; a start seen then is dropped.
   assign busy_out = exec_q || (state_q == ioa_pkg::IOA_ST_IDLE_SLOT);
   // Answers and architectural state leave straight from their registers.
   assign done_out = done_q;
   assign idle_slot_out = idle_q;
   assign acc_out = acc_q;
   assign result_nil_flag_out = nil_q;
   assign shift_out_flag_out = shout_q;
endmodule : ioa_alu

// ==== verif/ioa_alu_sva.sv ====
// Checker for the increment, OR and shift datapath, bound to its top module.
// Assumes the start, busy and done handshake described for ioa_alu.
`timescale 1ns/100ps
module ioa_alu_sva #(
   parameter int DATA_W = 8,
   parameter int ADDR_W = 7
) (
   // Clock and reset.
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   // Instruction.
   input wire logic start_in,
   input wire ioa_pkg::ioa_op_t op_in,
   input wire logic [ADDR_W-1:0] file_addr_in,
   input wire logic dest_sel_in,
   input wire logic [DATA_W-1:0] literal_in,
   // Answers.
   input wire logic busy_out,
   input wire logic done_out,
   input wire logic idle_slot_out,
   input wire logic [DATA_W-1:0] acc_out,
   input wire logic result_nil_flag_out,
   input wire logic shift_out_flag_out
);
   ioa_pkg::ioa_op_t op_q;
   logic dest_q, nil_q, sh_q, nil_upd;
   logic [DATA_W-1:0] lit_q, acc_q;
   // File-operand ops, other than the skip form, whose result should drive the nil flag.
   assign nil_upd = op_q inside {ioa_pkg::IOA_OP_ADD_ONE, ioa_pkg::IOA_OP_OR_FILE,
      ioa_pkg::IOA_OP_SHIFT_LEFT, ioa_pkg::IOA_OP_SHIFT_RIGHT};
   // Keeps the request and the state seen when it was taken.
   always_ff @(posedge ref_clk_in) begin
      if (start_in && !busy_out) begin
         op_q <= op_in;
         dest_q <= dest_sel_in;
         lit_q <= literal_in;
         acc_q <= acc_out;
         nil_q <= result_nil_flag_out;
         sh_q <= shift_out_flag_out;
      end
   end
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!reset_n_in);
   sequence s_take;
      start_in && !busy_out;
   endsequence
   sequence s_end;
      done_out && !idle_slot_out;
   endsequence
   a_normal_done: assert property (s_take ##0 op_in != ioa_pkg::IOA_OP_ADD_ONE_SKIP |-> ##[2:3] s_end)
      else $error("Plain op missed done.");
   a_skip_done: assert property (s_take ##0 op_in == ioa_pkg::IOA_OP_ADD_ONE_SKIP |-> ##[2:4] done_out)
      else $error("Skip op missed done.");
   a_skip_idle: assert property (done_out && op_q == ioa_pkg::IOA_OP_ADD_ONE_SKIP && !dest_q
      |-> idle_slot_out == (acc_out == '0))
      else $error("Idle slot wrong.");
   a_skip_flags: assert property (done_out && op_q == ioa_pkg::IOA_OP_ADD_ONE_SKIP
      |-> result_nil_flag_out == nil_q && shift_out_flag_out == sh_q)
      else $error("Skip op moved flags.");
   a_or_lit: assert property (done_out && op_q == ioa_pkg::IOA_OP_OR_LITERAL |-> acc_out == (acc_q | lit_q))
      else $error("Literal OR wrong.");
   a_nil_value: assert property (done_out && (op_q == ioa_pkg::IOA_OP_OR_LITERAL || (!dest_q && nil_upd))
      |-> result_nil_flag_out == (acc_out == '0))
      else $error("Nil flag wrong.");
   a_file_dest: assert property (done_out && dest_q && (nil_upd || op_q == ioa_pkg::IOA_OP_ADD_ONE_SKIP)
      |-> acc_out == acc_q)
      else $error("Accumulator hit on file write.");
   a_shift_fill: assert property (done_out && !dest_q |-> !(op_q == ioa_pkg::IOA_OP_SHIFT_LEFT && acc_out[0])
      && !(op_q == ioa_pkg::IOA_OP_SHIFT_RIGHT && acc_out[DATA_W-1]))
      else $error("Shift fill bit wrong.");
endmodule : ioa_alu_sva
bind ioa_alu ioa_alu_sva #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) u_sva (.ref_clk_in, .reset_n_in, .start_in,
   .op_in, .file_addr_in, .dest_sel_in, .literal_in, .busy_out, .done_out, .idle_slot_out, .acc_out,
   .result_nil_flag_out, .shift_out_flag_out);

// ==== verif/tb_incr_or_shift_alu_ops.sv ====
// Self-checking bench for the increment, OR and shift datapath.
// Assumes all file registers and the accumulator clear on reset.
`timescale 1ns/100ps
module tb_incr_or_shift_alu_ops;
   logic ref_clk_in, reset_n_in, start_in, dest_sel_in;
   ioa_pkg::ioa_op_t op_in;
   logic [6:0] file_addr_in;
   logic [7:0] literal_in, acc_out;
   logic busy_out, done_out, idle_slot_out, result_nil_flag_out, shift_out_flag_out;
   int n_errors = 0;
   int compares = 0;
   // Row digits: op, address, dest, literal, expected acc, expected {skip, shift, nil}.
   logic [35:0] rows [20] = '{36'h1_7f10_0000, 36'h5_7f10_0000, 36'h1_7f00_0030, 36'h3_0018_0830,
      36'h4_0010_0830, 36'h5_0000_0062, 36'h6_0000_0412, 36'h6_7f00_0010, 36'h3_000f_fff0,
      36'h4_0010_0ff0, 36'h5_0000_0fe2, 36'h2_0010_0fe6, 36'h6_0000_0001, 36'h2_0000_0011,
      36'h4_7f00_0030, 36'h3_000f_fff0, 36'h4_0510_0ff0, 36'h1_0500_0001, 36'h0_0000_0001,
      36'h2_0500_0005};
   ioa_alu DUT (.ref_clk_in, .reset_n_in, .start_in, .op_in, .file_addr_in, .dest_sel_in, .literal_in,
      .busy_out, .done_out, .idle_slot_out, .acc_out, .result_nil_flag_out, .shift_out_flag_out);
   // Free-running 4 ns clock.
   initial begin
      ref_clk_in = 1'b0;
      forever #2 ref_clk_in = ~ref_clk_in;
   end
   // Counts a comparison and reports a mismatch.
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // Issues one instruction, waits for done and checks the results.
   task run(input logic [35:0] r);
      @(posedge ref_clk_in);
      start_in <= 1'b1;
      op_in <= ioa_pkg::ioa_op_t'(r[34:32]);
      file_addr_in <= r[30:24];
      dest_sel_in <= r[20];
      literal_in <= r[19:12];
      @(posedge ref_clk_in);
      start_in <= 1'b0;
      for (int i = 0; i < 8 && done_out !== 1'b1; i++) @(negedge ref_clk_in);
      chk(done_out, 1'b1);
      chk(idle_slot_out, r[2]);
      chk(acc_out, r[11:4]);
      chk(result_nil_flag_out, r[0]);
      chk(shift_out_flag_out, r[1]);
   endtask : run
   // Prints the verdict and stops.
   task end_of_test;
      if (n_errors == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : end_of_test
   // Main sequence: table, refused request, reset in mid-run.
   initial begin
      reset_n_in = 1'b0;
      start_in = 1'b0;
      op_in = ioa_pkg::IOA_OP_NONE;
      file_addr_in = 7'h00;
      dest_sel_in = 1'b0;
      literal_in = 8'h00;
      repeat (10) @(posedge ref_clk_in);
      reset_n_in <= 1'b1;
      foreach (rows[i]) run(rows[i]);
      @(posedge ref_clk_in);
      start_in <= 1'b1;
      op_in <= ioa_pkg::IOA_OP_OR_LITERAL;
      literal_in <= 8'h01;
      @(posedge ref_clk_in);
      literal_in <= 8'h10;
      @(posedge ref_clk_in);
      start_in <= 1'b0;
      repeat (3) @(negedge ref_clk_in);
      chk(acc_out, 8'h01);
      @(posedge ref_clk_in);
      reset_n_in <= 1'b0;
      @(negedge ref_clk_in);
      chk({busy_out, done_out, result_nil_flag_out, shift_out_flag_out}, 8'h00);
      chk(acc_out, 8'h00);
      @(posedge ref_clk_in);
      reset_n_in <= 1'b1;
      run(36'h1_7f00_0010);
      end_of_test;
   end
   // Cuts a hang short well after the expected run length.
   initial begin
      repeat (2000) @(posedge ref_clk_in);
      n_errors++;
      end_of_test;
   end
endmodule : tb_incr_or_shift_alu_ops
